// File: hdl/tef_flag_chan.sv
// Event flags of one channel with read-then-write-zero acknowledge
`timescale 1ns/1ps
module tef_flag_chan
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       standby_in,
    input  wire logic [2:0] set_in,
    input  wire logic       rd_hit_in,
    input  wire logic       wr_hit_in,
    input  wire logic [2:0] wdata_in,
    output logic      [2:0] flags_out
);

    logic [2:0] flags_q;
    logic [2:0] flags_d;
    logic [2:0] armed_q;
    logic [2:0] clr;

    // Only a 0 written to a bit seen as 1 clears; set wins the same cycle
    always_comb
    begin
        clr     = {3{wr_hit_in}} & ~wdata_in & armed_q;
        flags_d = (flags_q & ~clr) | set_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            flags_q <= tef_pkg::TEF_FLAGS_INIT[2:0];
        else if (standby_in)
            flags_q <= tef_pkg::TEF_FLAGS_INIT[2:0];
        else
            flags_q <= flags_d;
    end

    // Any write consumes the read that armed it
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            armed_q <= 3'h0;
        else if (standby_in || wr_hit_in)
            armed_q <= 3'h0;
        else if (rd_hit_in)
            armed_q <= armed_q | flags_q;
    end

    assign flags_out = flags_q;

endmodule : tef_flag_chan

// File: hdl/tef_irq_en.sv
// Interrupt enable bits of one channel
`timescale 1ns/1ps
module tef_irq_en
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       standby_in,
    input  wire logic       wr_hit_in,
    input  wire logic [2:0] wdata_in,
    output logic      [2:0] en_out
);

    logic [2:0] en_q;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            en_q <= tef_pkg::TEF_EN_INIT[2:0];
        else if (standby_in)
            en_q <= tef_pkg::TEF_EN_INIT[2:0];
        else if (wr_hit_in)
            en_q <= wdata_in;
    end

    assign en_out = en_q;

endmodule : tef_irq_en

// File: hdl/tef_pkg.sv
// Constants and carriers for the timer channel event flag block
package tef_pkg;

    localparam int          TEF_NUM_CH      = 5;
    localparam int          TEF_NUM_EV      = 3;
    localparam int          TEF_BIT_WRAP    = 2;
    localparam int          TEF_BIT_B       = 1;
    localparam int          TEF_BIT_A       = 0;
    localparam logic [7:0]  TEF_FLAGS_INIT  = 8'hF8;
    localparam logic [7:0]  TEF_EN_INIT     = 8'hF8;
    localparam logic [4:0]  TEF_RSVD_ONES   = 5'h1F;
    localparam logic [7:0]  TEF_RD_IDLE     = 8'h00;
    localparam logic [15:0] TEF_COUNT_MAX   = 16'hFFFF;
    localparam logic [15:0] TEF_COUNT_MIN   = 16'h0000;
    localparam int          TEF_PHASE_CH    = 2;
    localparam int          TEF_PWM_CH_LO   = 3;
    localparam int          TEF_PWM_CH_HI   = 4;
    localparam logic        TEF_SEL_FLAGS   = 1'b0;
    localparam logic        TEF_SEL_EN      = 1'b1;

    // One CPU access on the internal 8-bit bus
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] chan;
        logic       sel;
        logic [7:0] wdata;
    } tef_bus_req_t;

    // What one channel's datapath shows this block
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] general_reg_a;
        logic [15:0] general_reg_b;
        logic        a_is_capture;
        logic        b_is_capture;
        logic        cap_a;
        logic        cap_b;
    } tef_chan_in_t;

endpackage : tef_pkg

// File: hdl/tef_top.sv
// Five-channel timer event flags, interrupt enables and requests
`timescale 1ns/1ps
module tef_top
(
    input  wire logic                                  mclk_in,
    input  wire logic                                  rst_n_in,
    input  wire logic                                  standby_in,
    input  wire tef_pkg::tef_bus_req_t                 bus_in,
    input  wire tef_pkg::tef_chan_in_t [4:0]           chan_in,
    input  wire logic                                  phase_mode_bit_in,
    input  wire logic                                  combined_mode_upper_in,
    input  wire logic                                  combined_mode_lower_in,
    output logic [7:0]                                 rd_data_out,
    output logic [4:0]                                 wrap_irq_request_out,
    output logic [4:0]                         match_capture_irq_request_b_out,
    output logic [4:0]                         match_capture_irq_request_a_out
);

    localparam int NCH = tef_pkg::TEF_NUM_CH;
    localparam int BW  = tef_pkg::TEF_BIT_WRAP;
    localparam int BB  = tef_pkg::TEF_BIT_B;
    localparam int BA  = tef_pkg::TEF_BIT_A;

    // Address decode shared by the read and write paths
    function automatic logic tef_hit(input tef_pkg::tef_bus_req_t r,
                                     input int ch,
                                     input logic sel);
        tef_hit = (r.chan == 3'(ch)) && (r.sel == sel);
    endfunction : tef_hit

    logic              rst_s1_q;
    logic              rst_s2_q;
    logic              rst_n;
    logic [NCH-1:0][2:0] flags;
    logic [NCH-1:0][2:0] en;
    logic [NCH-1:0][2:0] set_ev;
    logic [NCH-1:0][15:0] prev_q;
    logic [NCH-1:0]    updown;
    logic [NCH-1:0]    rd_f_hit;
    logic [NCH-1:0]    wr_f_hit;
    logic [NCH-1:0]    wr_e_hit;
    logic [7:0]        rd_data_d;
    logic [NCH-1:0][2:0] req_d;

    // Reset is asserted at once but released through two flops
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rst_n = rst_s2_q;

    // One domain: a standby cycle re-initialises state, so checks pause
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n || standby_in);

    // Only the up/down counting modes may wrap downward
    always_comb
    begin
        updown = '0;
        updown[tef_pkg::TEF_PHASE_CH] = phase_mode_bit_in;
        updown[tef_pkg::TEF_PWM_CH_LO] = combined_mode_upper_in
                                         & ~combined_mode_lower_in;
        updown[tef_pkg::TEF_PWM_CH_HI] = combined_mode_upper_in
                                         & ~combined_mode_lower_in;
    end

    // Previous count lets a wrap or a fresh match be seen as an event
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= '0;
        else
            for (int i = 0; i < NCH; i++)
                prev_q[i] <= chan_in[i].count;
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic up_wrap;
            logic dn_wrap;
            logic moved;
            logic match_a;
            logic match_b;

            assign moved   = chan_in[g].count != prev_q[g];
            assign up_wrap = (prev_q[g] == tef_pkg::TEF_COUNT_MAX)
                           && (chan_in[g].count == tef_pkg::TEF_COUNT_MIN);
            assign dn_wrap = updown[g]
                           && (prev_q[g] == tef_pkg::TEF_COUNT_MIN)
                           && (chan_in[g].count == tef_pkg::TEF_COUNT_MAX);
            // A match fires once when the count arrives, not while it sits
            assign match_a = !chan_in[g].a_is_capture && moved
                           && (chan_in[g].count == chan_in[g].general_reg_a);
            assign match_b = !chan_in[g].b_is_capture && moved
                           && (chan_in[g].count == chan_in[g].general_reg_b);

            assign set_ev[g][BW] = up_wrap | dn_wrap;
            assign set_ev[g][BB] = match_b
                                 | (chan_in[g].b_is_capture
                                    & chan_in[g].cap_b);
            assign set_ev[g][BA] = match_a
                                 | (chan_in[g].a_is_capture
                                    & chan_in[g].cap_a);

            assign rd_f_hit[g] = bus_in.rd
                               && tef_hit(bus_in, g, tef_pkg::TEF_SEL_FLAGS);
            assign wr_f_hit[g] = bus_in.wr
                               && tef_hit(bus_in, g, tef_pkg::TEF_SEL_FLAGS);
            assign wr_e_hit[g] = bus_in.wr
                               && tef_hit(bus_in, g, tef_pkg::TEF_SEL_EN);

            tef_flag_chan u_flags
            (
                .clk_in     (mclk_in),
                .rst_n_in   (rst_n),
                .standby_in (standby_in),
                .set_in     (set_ev[g]),
                .rd_hit_in  (rd_f_hit[g]),
                .wr_hit_in  (wr_f_hit[g]),
                .wdata_in   (bus_in.wdata[2:0]),
                .flags_out  (flags[g])
            );

            tef_irq_en u_en
            (
                .clk_in     (mclk_in),
                .rst_n_in   (rst_n),
                .standby_in (standby_in),
                .wr_hit_in  (wr_e_hit[g]),
                .wdata_in   (bus_in.wdata[2:0]),
                .en_out     (en[g])
            );

            assign req_d[g] = flags[g] & en[g];

            a_up_wrap_sets: assert property (
                (prev_q[g] == 16'hFFFF) && (chan_in[g].count == 16'h0000)
                |=> flags[g][BW])
                else $error("upward wrap did not set wrap flag");

            a_down_wrap_gate: assert property (
                !updown[g] && !flags[g][BW] && !up_wrap
                |=> !flags[g][BW])
                else $error("wrap flag set outside up/down mode");

            a_down_wrap_sets: assert property (
                updown[g] && (prev_q[g] == 16'h0000)
                && (chan_in[g].count == 16'hFFFF)
                |=> flags[g][BW])
                else $error("downward wrap did not set wrap flag");

            // Standby also clears flags, with no write behind it
            a_clear_needs_ack: assert property (
                $fell(flags[g][BA]) && !$past(standby_in)
                |-> $past(wr_f_hit[g] && !bus_in.wdata[BA]))
                else $error("flag A cleared without a 0 write");

            a_match_b_sets: assert property (
                match_b ##1 1'b1 |-> flags[g][BB])
                else $error("B compare match did not set flag B");

            a_capture_b_sets: assert property (
                chan_in[g].b_is_capture && chan_in[g].cap_b
                |=> flags[g][BB])
                else $error("B capture did not set flag B");

            a_match_a_sets: assert property (
                !chan_in[g].a_is_capture
                && (chan_in[g].count == chan_in[g].general_reg_a)
                && (chan_in[g].count != prev_q[g])
                |=> flags[g][BA])
                else $error("A compare match did not set flag A");

            a_capture_a_sets: assert property (
                chan_in[g].a_is_capture && chan_in[g].cap_a
                |=> flags[g][BA])
                else $error("A capture did not set flag A");

            a_write_one_keeps: assert property (
                flags[g][BW] && wr_f_hit[g] && bus_in.wdata[BW]
                |=> flags[g][BW])
                else $error("writing 1 changed the wrap flag");

            a_enable_write: assert property (
                wr_e_hit[g] |=> en[g] == $past(bus_in.wdata[2:0]))
                else $error("enable register did not take write");

            a_request_tracks: assert property (
                ##1 1'b1 |-> wrap_irq_request_out[g]
                          == $past(flags[g][BW] && en[g][BW]))
                else $error("wrap request does not follow flag and enable");

            a_request_b_a: assert property (
                match_capture_irq_request_b_out[g]
                |-> $past(flags[g][BB]) && $past(en[g][BB]))
                else $error("B request without flag and enable");

            a_request_a_gate: assert property (
                !en[g][BA] ##1 !en[g][BA]
                |-> !match_capture_irq_request_a_out[g])
                else $error("A request while A enable is 0");

            a_clear_b_ack: assert property (
                $fell(flags[g][BB]) && !$past(standby_in)
                |-> $past(wr_f_hit[g] && !bus_in.wdata[BB]))
                else $error("flag B cleared without a 0 write");

            a_clear_wrap_ack: assert property (
                $fell(flags[g][BW]) && !$past(standby_in)
                |-> $past(wr_f_hit[g] && !bus_in.wdata[BW]))
                else $error("wrap flag cleared without a 0 write");

            a_write_one_b: assert property (
                flags[g][BB] && wr_f_hit[g] && bus_in.wdata[BB]
                |=> flags[g][BB])
                else $error("writing 1 changed flag B");

            a_write_one_a: assert property (
                flags[g][BA] && wr_f_hit[g] && bus_in.wdata[BA]
                |=> flags[g][BA])
                else $error("writing 1 changed flag A");

            a_enable_keeps: assert property (
                !wr_e_hit[g] |=> en[g] == $past(en[g]))
                else $error("enable register changed without a write");

            a_request_b_tracks: assert property (
                ##1 1'b1 |-> match_capture_irq_request_b_out[g]
                          == $past(flags[g][BB] && en[g][BB]))
                else $error("B request does not follow flag and enable");

            a_request_a_tracks: assert property (
                ##1 1'b1 |-> match_capture_irq_request_a_out[g]
                          == $past(flags[g][BA] && en[g][BA]))
                else $error("A request does not follow flag and enable");

            a_request_wrap_gate: assert property (
                !en[g][BW] ##1 !en[g][BW]
                |-> !wrap_irq_request_out[g])
                else $error("wrap request while wrap enable is 0");

            // A strobe into a compare register must not look like a capture
            a_capture_a_mode: assert property (
                !chan_in[g].a_is_capture && !match_a && !flags[g][BA]
                |=> !flags[g][BA])
                else $error("flag A set with no match or capture");

            a_capture_b_mode: assert property (
                !chan_in[g].b_is_capture && !match_b && !flags[g][BB]
                |=> !flags[g][BB])
                else $error("flag B set with no match or capture");
        end
    endgenerate

    // Read mux: reserved bits read as 1, unknown channels read as 0
    always_comb
    begin
        rd_data_d = tef_pkg::TEF_RD_IDLE;
        for (int i = 0; i < NCH; i++)
        begin
            if (tef_hit(bus_in, i, tef_pkg::TEF_SEL_FLAGS))
                rd_data_d = {tef_pkg::TEF_RSVD_ONES, flags[i]};
            else if (tef_hit(bus_in, i, tef_pkg::TEF_SEL_EN))
                rd_data_d = {tef_pkg::TEF_RSVD_ONES, en[i]};
        end
    end

    // Read data is held until the next read so the CPU may sample late
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_out <= tef_pkg::TEF_RD_IDLE;
        else if (bus_in.rd)
            rd_data_out <= rd_data_d;
    end

    // Requests are registered, so they trail the flag by one cycle
    always_ff @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrap_irq_request_out            <= '0;
            match_capture_irq_request_b_out <= '0;
            match_capture_irq_request_a_out <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                wrap_irq_request_out[i]            <= req_d[i][BW];
                match_capture_irq_request_b_out[i] <= req_d[i][BB];
                match_capture_irq_request_a_out[i] <= req_d[i][BA];
            end
        end
    end

    a_flag_layout: assert property (
        bus_in.rd && (bus_in.chan < 3'h5) && (bus_in.sel == 1'b0)
        |=> rd_data_out == {5'h1F, $past(flags[bus_in.chan])})
        else $error("flag read data wrong");

    a_reserved_ones: assert property (
        bus_in.rd && (bus_in.chan < 3'h5)
        |=> rd_data_out[7:3] == 5'h1F)
        else $error("reserved bits did not read as 1");

    a_standby_init: assert property (
        disable iff (!rst_n)
        standby_in |=> (en == '0) && (flags == '0))
        else $error("standby did not initialise registers");

    a_standby_flags: assert property (
        disable iff (!rst_n)
        $past(standby_in) && bus_in.rd && (bus_in.chan < 3'h5)
        && (bus_in.sel == 1'b0)
        |=> rd_data_out == 8'hF8)
        else $error("flag register not at initial value");

    a_enable_layout: assert property (
        bus_in.rd && (bus_in.chan < 3'h5) && (bus_in.sel == 1'b1)
        |=> rd_data_out == {5'h1F, $past(en[bus_in.chan])})
        else $error("enable read data wrong");

    // Read data must stand until the next read strobe
    a_read_holds: assert property (
        !bus_in.rd |=> $stable(rd_data_out))
        else $error("read data changed without a read");

    a_reset_enables: assert property (
        $rose(rst_n) |-> en == '0)
        else $error("enables not at initial value after reset");

    a_reset_flags: assert property (
        $rose(rst_n) |-> flags == '0)
        else $error("flags not at initial value after reset");

endmodule : tef_top

// File: tb/tb_timer_channel_event_flags.sv
// Self-checking bench for the timer channel event flag block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_timer_channel_event_flags;
    logic                        mclk_in;
    logic                        rst_n_in;
    logic                        standby_in;
    tef_pkg::tef_bus_req_t       bus_in;
    tef_pkg::tef_chan_in_t [4:0] chan_w;
    logic                        phase_in;
    logic                        upper_in;
    logic                        lower_in;
    logic [7:0]                  rd_data_out;
    logic [4:0]                  wrap_req;
    logic [4:0]                  req_b;
    logic [4:0]                  req_a;
    logic [7:0]                  rd_v;
    int                          failures;
    int                          checked;

    tef_chan_model m (.clk_in(mclk_in), .chan_out(chan_w));

    tef_top dut (
        .mclk_in                         (mclk_in),
        .rst_n_in                        (rst_n_in),
        .standby_in                      (standby_in),
        .bus_in                          (bus_in),
        .chan_in                         (chan_w),
        .phase_mode_bit_in               (phase_in),
        .combined_mode_upper_in          (upper_in),
        .combined_mode_lower_in          (lower_in),
        .rd_data_out                     (rd_data_out),
        .wrap_irq_request_out            (wrap_req),
        .match_capture_irq_request_b_out (req_b),
        .match_capture_irq_request_a_out (req_a)
    );

    initial
    begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : tick

    task automatic reg_rd(input int ch, input logic sel);
        bus_in = '{rd: 1'b1, wr: 1'b0, chan: ch[2:0], sel: sel, wdata: 8'h00};
        tick(1);
        rd_v = rd_data_out;
        // An idle edge keeps back-to-back calls from re-driving a strobe
        bus_in.rd = 1'b0;
        tick(1);
    endtask : reg_rd

    task automatic reg_wr(input int ch, input logic sel, input logic [7:0] v);
        bus_in = '{rd: 1'b0, wr: 1'b1, chan: ch[2:0], sel: sel, wdata: v};
        tick(1);
        bus_in.wr = 1'b0;
        tick(1);
    endtask : reg_wr

    task automatic rd_chk(input int ch, input logic sel, input logic [7:0] e);
        reg_rd(ch, sel);
        `CHK(rd_v, e)
    endtask : rd_chk

    // Acknowledge every set flag: read arms, zero write clears
    task automatic clr(input int ch);
        reg_rd(ch, 1'b0);
        reg_wr(ch, 1'b0, 8'hF8);
    endtask : clr

    task automatic wrap_up(input int ch);
        m.set_count(ch, 16'hFFFF);
        tick(1);
        m.set_count(ch, 16'h0000);
        tick(1);
    endtask : wrap_up

    task automatic final_report();
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Down-wrap cases: channel, phase bit, upper, lower, flag expected
    int dn_tab [6][5] = '{'{0, 1, 1, 0, 0}, '{2, 0, 1, 0, 0}, '{2, 1, 0, 0, 1},
                          '{3, 0, 1, 1, 0}, '{3, 0, 1, 0, 1}, '{4, 0, 1, 0, 1}};

    initial
    begin
        failures = 0;
        checked = 0;
        rst_n_in = 1'b0;
        standby_in = 1'b0;
        bus_in = '0;
        {phase_in, upper_in, lower_in} = 3'b000;
        tick(10);
        rst_n_in = 1'b1;
        tick(3);
        for (int ch = 0; ch < 6; ch++)
        begin
            rd_chk(ch, 1'b0, (ch < 5) ? 8'hF8 : 8'h00);
            rd_chk(ch, 1'b1, (ch < 5) ? 8'hF8 : 8'h00);
            reg_wr(ch, 1'b1, 8'h00);
            rd_chk(ch, 1'b1, (ch < 5) ? 8'hF8 : 8'h00);
            reg_wr(ch, 1'b1, 8'h07);
            rd_chk(ch, 1'b1, (ch < 5) ? 8'hFF : 8'h00);
        end
        for (int ch = 0; ch < 5; ch++)
        begin
            wrap_up(ch);
            reg_wr(ch, 1'b0, 8'hF8);
            `CHK(wrap_req, 5'(1 << ch))
            rd_chk(ch, 1'b0, 8'hFC);
            reg_wr(ch, 1'b0, 8'hFF);
            rd_chk(ch, 1'b0, 8'hFC);
            reg_wr(ch, 1'b0, 8'hF8);
            tick(1);
            `CHK(wrap_req, 5'h00)
            rd_chk(ch, 1'b0, 8'hF8);
        end
        for (int i = 0; i < 6; i++)
        begin
            {phase_in, upper_in, lower_in} =
                {dn_tab[i][1] != 0, dn_tab[i][2] != 0, dn_tab[i][3] != 0};
            m.set_count(dn_tab[i][0], 16'hFFFF);
            tick(1);
            rd_chk(dn_tab[i][0], 1'b0, (dn_tab[i][4] != 0) ? 8'hFC : 8'hF8);
            {phase_in, upper_in, lower_in} = 3'b000;
            m.set_count(dn_tab[i][0], 16'h0000);
            tick(1);
            clr(dn_tab[i][0]);
        end
        m.set_count(1, 16'h1234);
        tick(1);
        rd_chk(1, 1'b0, 8'hF9);
        clr(1);
        m.set_count(1, 16'h5678);
        tick(1);
        rd_chk(1, 1'b0, 8'hFA);
        clr(1);
        m.set_capture(1, 1'b1, 1'b1);
        m.set_count(1, 16'h1234);
        tick(1);
        rd_chk(1, 1'b0, 8'hF8);
        m.pulse_cap(1, 1'b0);
        rd_chk(1, 1'b0, 8'hF9);
        clr(1);
        m.pulse_cap(1, 1'b1);
        rd_chk(1, 1'b0, 8'hFA);
        clr(1);
        m.set_capture(1, 1'b0, 1'b0);
        m.pulse_cap(1, 1'b0);
        rd_chk(1, 1'b0, 8'hF8);
        reg_wr(4, 1'b1, 8'hF8);
        wrap_up(4);
        m.set_count(4, 16'h1234);
        tick(1);
        m.set_count(4, 16'h5678);
        tick(2);
        `CHK({wrap_req[4], req_b[4], req_a[4]}, 3'b000)
        reg_wr(4, 1'b1, 8'h07);
        tick(1);
        `CHK({wrap_req[4], req_b[4], req_a[4]}, 3'b111)
        reg_wr(4, 1'b1, 8'h03);
        tick(1);
        `CHK({wrap_req[4], req_b[4], req_a[4]}, 3'b011)
        standby_in = 1'b1;
        tick(1);
        standby_in = 1'b0;
        rd_chk(4, 1'b0, 8'hF8);
        `CHK({wrap_req[4], req_b[4], req_a[4]}, 3'b000)
        rd_chk(4, 1'b1, 8'hF8);
        final_report();
    end

    // The sequence above needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk_in);
        failures++;
        final_report();
    end
endmodule : tb_timer_channel_event_flags

// File: tb/tef_chan_model.sv
// Behavioural model of the five channel counters feeding the event logic
`timescale 1ns/1ps
module tef_chan_model
(
    input  wire logic                        clk_in,
    output tef_pkg::tef_chan_in_t [4:0]      chan_out
);
    initial
    begin
        for (int i = 0; i < 5; i++)
        begin
            chan_out[i] = {16'h0000, 16'h1234, 16'h5678, 4'h0};
        end
    end

    task automatic set_count(input int ch, input logic [15:0] v);
        chan_out[ch].count = v;
    endtask : set_count

    task automatic set_capture(input int ch, input logic a, input logic b);
        chan_out[ch].a_is_capture = a;
        chan_out[ch].b_is_capture = b;
    endtask : set_capture

    // Capture load is a single-cycle strobe, dropped just after one edge
    task automatic pulse_cap(input int ch, input logic is_b);
        if (is_b)
        begin
            chan_out[ch].cap_b = 1'b1;
        end
        else
        begin
            chan_out[ch].cap_a = 1'b1;
        end
        @(posedge clk_in);
        #1;
        chan_out[ch].cap_a = 1'b0;
        chan_out[ch].cap_b = 1'b0;
    endtask : pulse_cap
endmodule : tef_chan_model
